// ==== hw/standby_pkg.sv ====
// Constants and state types for the standby and reset sequencer.
// Assumes a single 25 MHz clock domain; pins arrive already synchronous.
// Overview of operation
// RL1: Halt instruction enters HALT state
// RL2: HALT stops fetch, clock keeps running
// RL3: Unmasked interrupt or reset leaves HALT
// RL4: Stop instruction enters STOP type A, oscillator off
// RL5: Only NMI or reset exits STOP A; a low stop-control input also moves it to STOP B
// RL6: STOP A exit waits timer-1 programmed delay
// RL7: Software reads standby flag for wake cause
// RL8: Low stop-control input enters STOP type B
// RL9: Stop-control rising starts wake-up sequence
// RL10: Fixed 52.4 ms wait, then start at 0
// RL11: External reset low extends stabilization time
// RL12: Low reset input initializes the device
// RL13: Strobes held high while reset asserted
// RL14: NMI recognized on its falling edge
// RL15: Flag set entering STOP, cleared by power-up
// RL16: No fetch during stabilization interval
package standby_pkg;

  localparam real CLK_MHZ = 25.0;
  localparam real STAB_FIXED_US = 52400.0;
  localparam int STAB_FIXED_CYC = int'(STAB_FIXED_US * CLK_MHZ);
  localparam int STAB_MAX_US = 52400;
  localparam int STAB_MAX_CYC = int'(real'(STAB_MAX_US) * CLK_MHZ);
  localparam int CNT_W = 21;
  localparam logic [CNT_W-1:0] CNT_ZERO = 21'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 21'h000001;
  localparam logic [15:0] RESTART_ADDR = 16'h0000;
  localparam logic STROBE_IDLE = 1'b1;

  typedef enum logic [2:0] {
    RUN,
    HALT,
    STOP_A,
    STOP_B,
    STAB_A,
    STAB_B
  } sb_state_t;

endpackage : standby_pkg

// ==== hw/stab_counter.sv ====
// Down counter used for oscillator stabilization delays.
// Assumes load is a one-cycle pulse; done pulses once when count expires.
`timescale 1ns/1ps
module stab_counter #(
  parameter int WIDTH = 21
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic load, // Load pulse
  input wire logic [WIDTH-1:0] loadVal, // Cycles to wait
  output logic busy, // Counting
  output logic done // Expiry pulse
);
  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (load) begin
      cnt_nxt = loadVal;
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      if (cnt_r <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy = busy_r;
  assign done = done_r;
endmodule : stab_counter

// ==== hw/standby_mode_controller.sv ====
// Standby sequencer: HALT, STOP type A/B, stabilization and wake control.
// Assumes the CPU core samples cpuRun and restart; pins are synchronous.
`timescale 1ns/1ps
module standby_mode_controller
  import standby_pkg::*;
#(
  parameter int STAB_FIXED = standby_pkg::STAB_FIXED_CYC, // Fixed B wait
  parameter int STAB_MAX = standby_pkg::STAB_MAX_CYC // Max A wait
) (
  input wire logic clk, // 25 MHz system clock
  input wire logic nrst, // Reset pin, active low
  input wire logic haltInstr, // Halt instruction executed
  input wire logic stopInstr, // Stop instruction executed
  input wire logic irqPending, // Unmasked interrupt request
  input wire logic nmiPin, // NMI pin level, falls to request
  input wire logic stopPin, // Stop-control pin level
  input wire logic powerUp, // Power-up init pulse
  input wire logic [standby_pkg::CNT_W-1:0] timer1Val, // Programmed wait
  input wire logic rdStrobeCpu, // Core read strobe, active low
  input wire logic wrStrobeCpu, // Core write strobe, active low
  output logic cpuRun, // Fetch/execute allowed
  output logic oscEnable, // Oscillator running
  output logic restart, // Pulse: restart at address
  output logic [15:0] restartAddr, // Restart address
  output logic standbyFlag, // Standby flag value
  output logic nRd, // Read strobe pin
  output logic nWr, // Write strobe pin
  output logic [2:0] modeState // Current mode
);
  initial begin
    if (STAB_FIXED < 1 || STAB_FIXED >= (1 << CNT_W)) $error("STAB_FIXED");
    if (STAB_MAX < 1 || STAB_MAX >= (1 << CNT_W)) $error("STAB_MAX");
  end

  sb_state_t state_r, state_nxt;
  logic nmiPrev_r, nmiPrev_nxt;
  logic flag_r, flag_nxt;
  logic run_r, run_nxt;
  logic osc_r, osc_nxt;
  logic rst_r, rst_nxt;
  logic nRd_r, nRd_nxt;
  logic nWr_r, nWr_nxt;
  logic load;
  logic [CNT_W-1:0] loadVal;
  logic stabBusy;
  logic stabDone;
  logic nmiFall;
  logic [CNT_W-1:0] aWait;
  logic [15:0] addr_r;

  stab_counter #(.WIDTH(CNT_W)) u_stab (
    .clk(clk),
    .nrst(nrst),
    .load(load),
    .loadVal(loadVal),
    .busy(stabBusy),
    .done(stabDone)
  );

  assign nmiFall = nmiPrev_r && !nmiPin; // RL14

  // Clamp the programmed wait to the documented maximum
  always_comb begin
    if (timer1Val > CNT_W'(STAB_MAX)) begin
      aWait = CNT_W'(STAB_MAX); // RL6
    end else if (timer1Val == CNT_ZERO) begin
      aWait = CNT_ONE;
    end else begin
      aWait = timer1Val;
    end
  end

  always_comb begin
    state_nxt = state_r;
    flag_nxt = flag_r;
    rst_nxt = 1'b0;
    load = 1'b0;
    loadVal = aWait;
    nmiPrev_nxt = nmiPin;
    if (powerUp) begin
      flag_nxt = 1'b0; // RL15
    end
    // Stop pin low overrides every state except STOP_B itself
    if (!stopPin && state_r != STOP_B) begin
      state_nxt = STOP_B; // RL8
      flag_nxt = 1'b1; // RL15
    end else begin
      unique case (state_r)
        RUN: begin
          if (stopInstr) begin
            state_nxt = STOP_A; // RL4
            flag_nxt = 1'b1; // RL15
          end else if (haltInstr) begin
            state_nxt = HALT; // RL1
          end
        end
        HALT: begin
          if (irqPending || nmiFall) begin
            state_nxt = RUN; // RL3
          end
        end
        STOP_A: begin
          if (nmiFall) begin
            state_nxt = STAB_A; // RL5
            load = 1'b1; // RL6
          end
        end
        STOP_B: begin
          if (stopPin) begin
            state_nxt = STAB_B; // RL9
            load = 1'b1;
            loadVal = CNT_W'(STAB_FIXED); // RL10
          end
        end
        STAB_A: begin
          if (stabDone) begin
            state_nxt = RUN; // RL16
          end
        end
        STAB_B: begin
          if (stabDone) begin
            state_nxt = RUN; // RL10
            rst_nxt = 1'b1;
          end
        end
        // Two spare state codes can only come from an upset
        default: begin
          state_nxt = RUN;
        end
      endcase
    end
    run_nxt = (state_nxt == RUN); // RL2 RL16
    osc_nxt = !(state_nxt == STOP_A || state_nxt == STOP_B);
    nRd_nxt = run_nxt ? rdStrobeCpu : STROBE_IDLE;
    nWr_nxt = run_nxt ? wrStrobeCpu : STROBE_IDLE;
  end

  // Reset pin is async: wake from any mode lands here (RL11 via length)
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= RUN; // RL12 RL3 RL5
      nmiPrev_r <= 1'b1;
      run_r <= 1'b0;
      addr_r <= RESTART_ADDR;
      osc_r <= 1'b1;
      rst_r <= 1'b0;
      nRd_r <= STROBE_IDLE; // RL13
      nWr_r <= STROBE_IDLE; // RL13
    end else begin
      state_r <= state_nxt;
      nmiPrev_r <= nmiPrev_nxt;
      run_r <= run_nxt;
      addr_r <= RESTART_ADDR;
      osc_r <= osc_nxt;
      rst_r <= rst_nxt;
      nRd_r <= nRd_nxt;
      nWr_r <= nWr_nxt;
    end
  end

  // The flag must survive the reset pin so software can tell a wake
  // from standby apart from power-up; only powerUp clears it
  always_ff @(posedge clk) begin
    flag_r <= flag_nxt; // RL15 RL7
  end

  assign cpuRun = run_r;
  assign oscEnable = osc_r;
  assign restart = rst_r;
  assign restartAddr = addr_r;
  assign standbyFlag = flag_r; // RL7
  assign nRd = nRd_r;
  assign nWr = nWr_r;
  assign modeState = state_r;
endmodule : standby_mode_controller

// ==== testbench/standby_chk.sv ====
// Port checker for the standby sequencer.
// Assumes one clock domain; bound to the design from the testbench.
`timescale 1ns/1ps
module standby_chk #(
  parameter int STAB_FIXED = 20,
  parameter int STAB_MAX = 20
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic haltInstr,
  input wire logic stopInstr,
  input wire logic irqPending,
  input wire logic nmiPin,
  input wire logic stopPin,
  input wire logic cpuRun,
  input wire logic oscEnable,
  input wire logic restart,
  input wire logic [15:0] restartAddr,
  input wire logic nRd,
  input wire logic nWr,
  input wire logic [2:0] modeState
);
  localparam int BMAX = STAB_FIXED + 3;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_halt;
    modeState == 0 && haltInstr && !stopInstr && stopPin |=> modeState == 1;
  endproperty
  a_halt: assert property (p_halt) else $error("halt entry");
  property p_wakeH;
    modeState == 1 && irqPending && stopPin |=> modeState == 0 && cpuRun;
  endproperty
  a_wakeH: assert property (p_wakeH) else $error("halt exit");
  property p_stopA;
    modeState == 0 && stopInstr && stopPin |=> modeState == 2 && !oscEnable;
  endproperty
  a_stopA: assert property (p_stopA) else $error("stop A entry");
  property p_stayA;
    modeState == 2 && nmiPin && stopPin |=> $stable(modeState);
  endproperty
  a_stayA: assert property (p_stayA) else $error("stop A left");
  property p_nmi;
    modeState == 2 && $fell(nmiPin) && stopPin |=> modeState == 4;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi wake");
  property p_stopB;
    !stopPin |=> modeState == 3 && !oscEnable && !cpuRun;
  endproperty
  a_stopB: assert property (p_stopB) else $error("stop B entry");
  property p_wakeB;
    $rose(modeState == 5) |-> (modeState == 5)[*8] ##[1:BMAX]
      (restart && cpuRun && restartAddr == 16'h0000);
  endproperty
  a_wakeB: assert property (p_wakeB) else $error("stop B wake");
  property p_strb;
    !cpuRun |-> nRd && nWr;
  endproperty
  a_strb: assert property (p_strb) else $error("strobe idle");
  c_halt: cover property (modeState == 1 ##1 modeState == 0);
  c_nmi: cover property (modeState == 2 ##1 modeState == 4);
  c_restart: cover property (restart);
endmodule : standby_chk

// ==== testbench/ext_standby_ctl.sv ====
// Model of the external reset and stop-control circuit.
// Assumes bench requests change just after a clock edge.
`timescale 1ns/1ps
module ext_standby_ctl (
  input wire logic clk, // System clock
  input wire logic rstReq, // Bench asks for reset
  input wire logic stopReq, // Bench asks for STOP B
  output logic nrst, // Reset pin, low active
  output logic stopPin // Stop-control pin
);
  initial nrst = 1'b0;
  initial stopPin = 1'b1;
  // Pins move just after an edge so the sequencer sees clean levels
  always @(posedge clk) begin
    nrst <= #2 !rstReq;
    stopPin <= #2 !stopReq;
  end
endmodule : ext_standby_ctl

// ==== testbench/testbench.sv ====
// Bench for the standby sequencer with short stabilization counts.
// Assumes the external circuit model drives reset and stop pins.
`timescale 1ns/1ps
module testbench;
  import standby_pkg::*;
  logic clk = 0, rstReq = 1, stopReq = 0, haltInstr = 0, stopInstr = 0;
  logic irqPending = 0, nmiPin = 1, powerUp = 0;
  logic rdStrobeCpu = 1, wrStrobeCpu = 1, nrst, stopPin, cpuRun;
  logic oscEnable, restart, standbyFlag, nRd, nWr;
  logic [CNT_W-1:0] timer1Val = 21'h00000A;
  logic [15:0] restartAddr;
  logic [2:0] modeState;
  int failures = 0, checks_done = 0, n;
  // Row: halt, stop, irq, nmi level, then expected mode
  logic [6:0] rows [5] = '{7'h49, 7'h29, 7'h18, 7'h6A, 7'h1A};
  int tv [3] = '{10, 0, 50};
  int tx [3] = '{11, 2, 21};
  ext_standby_ctl i_ext (.clk, .rstReq, .stopReq, .nrst, .stopPin);
  standby_mode_controller #(.STAB_FIXED(20), .STAB_MAX(20)) i_dut (.clk,
    .nrst, .haltInstr, .stopInstr, .irqPending, .nmiPin, .stopPin, .powerUp,
    .timer1Val, .rdStrobeCpu, .wrStrobeCpu, .cpuRun, .oscEnable, .restart,
    .restartAddr, .standbyFlag, .nRd, .nWr, .modeState);
  always #20 clk = ~clk;
  task cyc;
    @(posedge clk) #2;
  endtask : cyc
  task chk(input logic [20:0] g, input logic [20:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    #100000;
    failures++;
    report_and_stop;
  end
  initial begin
    repeat (16) cyc;
    chk(nRd & nWr, 1);
    rstReq = 0;
    repeat (2) cyc;
    for (int k = 0; k < 5; k++) begin
      {haltInstr, stopInstr, irqPending, nmiPin} = rows[k][6:3];
      cyc;
      {haltInstr, stopInstr, irqPending, nmiPin} = 4'h1;
      chk(modeState, rows[k][2:0]);
    end
    for (int j = 0; j < 3; j++) begin
      timer1Val = tv[j];
      nmiPin = 0;
      cyc;
      nmiPin = 1;
      chk(modeState, 3'h4);
      for (n = 0; modeState == 3'h4 && n < 99; n++) begin
        chk(cpuRun, 0);
        cyc;
      end
      chk(n, tx[j]);
      stopInstr = 1;
      cyc;
      stopInstr = 0;
      chk(oscEnable, 0);
    end
    stopReq = 1;
    repeat (3) cyc;
    chk({modeState, oscEnable, standbyFlag}, 5'h0D);
    stopReq = 0;
    rstReq = 1;
    rdStrobeCpu = 0;
    repeat (3) cyc;
    chk({cpuRun, nRd, nWr, standbyFlag}, 4'h7);
    rstReq = 0;
    repeat (3) cyc;
    chk({cpuRun, nRd}, 2'h2);
    rdStrobeCpu = 1;
    powerUp = 1;
    cyc;
    powerUp = 0;
    cyc;
    chk(standbyFlag, 0);
    stopReq = 1;
    repeat (3) cyc;
    stopReq = 0;
    for (n = 0; restart !== 1'b1 && n < 99; n++) cyc;
    chk(n >= 20 && n <= 25, 1);
    chk({cpuRun, restartAddr}, 17'h10000);
    report_and_stop;
  end
endmodule : testbench
bind standby_mode_controller standby_chk #(.STAB_FIXED(STAB_FIXED),
  .STAB_MAX(STAB_MAX)) u_chk (.clk, .nrst, .haltInstr, .stopInstr,
  .irqPending, .nmiPin, .stopPin, .cpuRun, .oscEnable, .restart,
  .restartAddr, .nRd, .nWr, .modeState);
